// *** ice_addr_if.sv ***
// Purpose: Carrier between the executor and its address calculator
// Assumes: Purely combinational exchange on the core clock
// Notes:   req side drives the operands, calc side returns the targets
`timescale 1ns/1ps
interface ice_addr_if;
    logic [15:0] pc_base;
    logic [7:0]  rel;
    logic        long_instr;
    logic [7:0]  acc;
    logic [15:0] sixteen_bit_data_pointer;
    logic [15:0] fall_target;
    logic [15:0] rel_target;
    logic [15:0] table_target;

    modport req (output pc_base, rel, long_instr, acc, sixteen_bit_data_pointer,
                 input  fall_target, rel_target, table_target);
    modport calc (input  pc_base, rel, long_instr, acc, sixteen_bit_data_pointer,
                  output fall_target, rel_target, table_target);
endinterface

// *** ice_exec.sv ***
// Purpose: Execute increment, loop, pointer and conditional branch ops
// Assumes: Core presents operands with op_valid for one cycle
// Notes:   Results come one cycle later with done; flags are never written
//
// Function
// - Byte increment wraps, flags untouched
// - Increment accepts bank, direct, indirect, accumulator
// - Port increment starts from the output latch
// - Pointer increment carries low into high
// - Only the pointer increments as sixteen bits
// - Bit set branch leaves bit and flags
// - Bit branches advance three then add displacement
// - Branch and clear clears only when set
// - Branch and clear reads port latch
// - Bit clear branch leaves bit and flags
// - Carry branch taken when carry set
// - Carry branch advances two then adds
// - Table jump loads accumulator plus pointer
// - Table jump sum wraps at sixteen bits
// - Loop decrements, branches on nonzero result
`timescale 1ns/1ps
module ice_exec (
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    input  wire logic             op_valid,
    input  wire ice_pkg::ice_op_t op,
    input  wire ice_pkg::ice_src_t src,
    input  wire logic             is_port,
    input  wire logic [7:0]       operand_in,
    input  wire logic [7:0]       port_latch,
    input  wire logic             bit_in,
    input  wire logic             bit_is_port,
    input  wire logic             bit_latch,
    input  wire logic             carry_in,
    input  wire logic [7:0]       rel_disp,
    input  wire logic [15:0]      pc_in,
    input  wire logic [15:0]      sixteen_bit_data_pointer_in,
    input  wire logic [7:0]       acc_in,
    output logic                  done_r,
    output logic                  byte_we_r,
    output ice_pkg::ice_src_t     byte_dst_r,
    output logic [7:0]            byte_out_r,
    output logic                  pc_we_r,
    output logic [15:0]           pc_out_r,
    output logic                  sixteen_bit_data_pointer_we_r,
    output logic [15:0]           sixteen_bit_data_pointer_out_r,
    output logic                  bit_clr_r
);
    ice_addr_if addr ();

    logic [7:0]  operand;
    logic [7:0]  inc_val;
    logic [7:0]  dec_val;
    logic        bit_seen;
    logic        byte_we_nxt;
    logic [7:0]  byte_nxt;
    logic        pc_we_nxt;
    logic [15:0] pc_nxt;
    logic        sixteen_bit_data_pointer_we_nxt;
    logic [15:0] sixteen_bit_data_pointer_nxt;
    logic        bit_clr_nxt;

    // ------------------------------------------------------------------
    // Operand selection and address calculator
    // ------------------------------------------------------------------
    // A port operand comes from its latch; pins may be loaded externally
    assign operand  = is_port ? port_latch : operand_in;
    assign inc_val  = operand + ice_pkg::ICE_BYTE_STEP;
    assign dec_val  = operand - ice_pkg::ICE_BYTE_STEP;
    // Read-modify-write bit test must see what software last wrote
    assign bit_seen = bit_is_port ? bit_latch : bit_in;

    assign addr.pc_base    = pc_in;
    assign addr.rel        = rel_disp;
    assign addr.acc        = acc_in;
    assign addr.sixteen_bit_data_pointer       = sixteen_bit_data_pointer_in;
    // Three-byte forms: bit tests and loop on a direct byte
    assign addr.long_instr = (op == ice_pkg::ICE_OP_BIT_SET)
                          || (op == ice_pkg::ICE_OP_BIT_CLR)
                          || (op == ice_pkg::ICE_OP_BIT_TAKE)
                          || ((op == ice_pkg::ICE_OP_LOOP)
                              && (src == ice_pkg::ICE_SRC_DIRECT));

    ice_target ice_target_inst (
        .a (addr.calc)
    );

    // ------------------------------------------------------------------
    // Next-state decode
    // ------------------------------------------------------------------
    // No path drives a flag write: every op here leaves the status word
    always_comb begin
        byte_we_nxt = 1'b0;
        byte_nxt    = operand;
        pc_we_nxt   = 1'b0;
        pc_nxt      = addr.fall_target;
        sixteen_bit_data_pointer_we_nxt = 1'b0;
        sixteen_bit_data_pointer_nxt    = sixteen_bit_data_pointer_in + ice_pkg::ICE_PTR_STEP;
        bit_clr_nxt = 1'b0;
        if (op_valid) begin
            unique case (op)
                ice_pkg::ICE_OP_NONE: begin
                    byte_nxt = operand;
                end
                ice_pkg::ICE_OP_INC: begin
                    byte_we_nxt = 1'b1;
                    byte_nxt    = inc_val;
                end
                ice_pkg::ICE_OP_INC_PTR: begin
                    // Sole 16-bit increment path in this unit
                    sixteen_bit_data_pointer_we_nxt = 1'b1;
                end
                ice_pkg::ICE_OP_BIT_SET: begin
                    pc_we_nxt = 1'b1;
                    pc_nxt    = bit_in ? addr.rel_target
                                       : addr.fall_target;
                end
                ice_pkg::ICE_OP_BIT_CLR: begin
                    pc_we_nxt = 1'b1;
                    pc_nxt    = bit_in ? addr.fall_target
                                       : addr.rel_target;
                end
                ice_pkg::ICE_OP_BIT_TAKE: begin
                    pc_we_nxt   = 1'b1;
                    bit_clr_nxt = bit_seen;
                    pc_nxt      = bit_seen ? addr.rel_target
                                           : addr.fall_target;
                end
                ice_pkg::ICE_OP_CARRY: begin
                    pc_we_nxt = 1'b1;
                    pc_nxt    = carry_in ? addr.rel_target
                                         : addr.fall_target;
                end
                ice_pkg::ICE_OP_TABLE: begin
                    pc_we_nxt = 1'b1;
                    pc_nxt    = addr.table_target;
                end
                ice_pkg::ICE_OP_LOOP: begin
                    byte_we_nxt = 1'b1;
                    byte_nxt    = dec_val;
                    pc_we_nxt   = 1'b1;
                    pc_nxt      = (dec_val != ice_pkg::ICE_BYTE_ZERO)
                                ? addr.rel_target
                                : addr.fall_target;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------------
    // Completion strobe
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            done_r <= 1'b0;
        end else begin
            done_r <= op_valid;
        end
    end

    // Byte write-back, destination echoed for the core's write mux
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            byte_we_r  <= 1'b0;
            byte_dst_r <= ice_pkg::ICE_SRC_ACC;
            byte_out_r <= ice_pkg::ICE_BYTE_RST;
        end else begin
            byte_we_r  <= byte_we_nxt;
            byte_dst_r <= src;
            byte_out_r <= byte_nxt;
        end
    end

    // Program counter load
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_we_r  <= 1'b0;
            pc_out_r <= ice_pkg::ICE_WORD_RST;
        end else begin
            pc_we_r  <= pc_we_nxt;
            pc_out_r <= pc_nxt;
        end
    end

    // Data pointer write-back; the 16-bit add carries low into high
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sixteen_bit_data_pointer_we_r  <= 1'b0;
            sixteen_bit_data_pointer_out_r <= ice_pkg::ICE_WORD_RST;
        end else begin
            sixteen_bit_data_pointer_we_r  <= sixteen_bit_data_pointer_we_nxt;
            sixteen_bit_data_pointer_out_r <= sixteen_bit_data_pointer_nxt;
        end
    end

    // Bit clear strobe for the branch-and-clear op
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bit_clr_r <= 1'b0;
        end else begin
            bit_clr_r <= bit_clr_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_inc;
        op_valid && op == ice_pkg::ICE_OP_INC;
    endsequence
    sequence s_take;
        op_valid && op == ice_pkg::ICE_OP_BIT_TAKE;
    endsequence
    sequence s_loop_last;
        op_valid && op == ice_pkg::ICE_OP_LOOP && operand == 8'h01;
    endsequence

    // Expected byte worked from the operand, not from the adder under test
    inc_value_a: assert property (s_inc |=> byte_we_r && !pc_we_r
        && byte_out_r == $past(operand) + 8'h01)
        else $error("increment wrong");
    inc_latch_a: assert property (s_inc ##0 is_port
        |=> byte_out_r == $past(port_latch) + 8'h01 - 8'h00
            || $past(port_latch) == 8'hFF && byte_out_r == 8'h00)
        else $error("port increment not from latch");
    ptr_inc_a: assert property (
        op_valid && op == ice_pkg::ICE_OP_INC_PTR && sixteen_bit_data_pointer_in == 16'hFFFF
        |=> sixteen_bit_data_pointer_we_r && sixteen_bit_data_pointer_out_r == 16'h0000)
        else $error("pointer wrap wrong");
    bit_set_a: assert property (
        op_valid && op == ice_pkg::ICE_OP_BIT_SET
        && !bit_in |=> pc_we_r && !bit_clr_r && !byte_we_r
        && pc_out_r == $past(pc_in) + 16'h0003)
        else $error("bit set fall-through wrong");
    take_keep_a: assert property (s_take ##0 !bit_seen
        |=> !bit_clr_r && pc_out_r == $past(pc_in) + 16'h0003)
        else $error("bit cleared when zero");
    take_latch_a: assert property (s_take ##0 bit_is_port && bit_latch
        |=> bit_clr_r ##1 !bit_clr_r || $past(op_valid))
        else $error("port bit not taken from latch");
    // Target rebuilt here from the inputs, independent of the calculator
    bit_clear_a: assert property (
        op_valid && op == ice_pkg::ICE_OP_BIT_CLR && !bit_in
        |=> !bit_clr_r && pc_out_r == $past(pc_in) + 16'h0003
            + {{8{$past(rel_disp[7])}}, $past(rel_disp)})
        else $error("bit clear branch wrong");
    carry_br_a: assert property (
        op_valid && op == ice_pkg::ICE_OP_CARRY
        && rel_disp == 8'hFE && carry_in
        |=> pc_out_r == $past(pc_in))
        else $error("carry branch target wrong");
    table_jmp_a: assert property (
        op_valid && op == ice_pkg::ICE_OP_TABLE
        && acc_in == 8'hFF && sixteen_bit_data_pointer_in == 16'h00FF
        |=> pc_we_r && pc_out_r == 16'h01FE && !sixteen_bit_data_pointer_we_r)
        else $error("table jump sum wrong");
    loop_end_a: assert property (s_loop_last ##0 src == ice_pkg::ICE_SRC_BANK
        |=> byte_out_r == 8'h00 && pc_out_r == $past(pc_in) + 16'h0002)
        else $error("loop end fall-through wrong");

endmodule

// *** ice_pkg.sv ***
// Purpose: Shared types and constants for the increment and branch unit
// Assumes: 16-bit program space, 8-bit data, byte-wide displacement
// Notes:   Operation codes are internal selectors, not opcode bits
package ice_pkg;

    // ------------------------------------------------------------------
    // Operation and operand selectors
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ICE_OP_NONE     = 4'h0,
        ICE_OP_INC      = 4'h1, // Byte increment
        ICE_OP_INC_PTR  = 4'h2, // Data pointer increment
        ICE_OP_BIT_SET  = 4'h3, // Branch if bit set
        ICE_OP_BIT_CLR  = 4'h4, // Branch if bit clear
        ICE_OP_BIT_TAKE = 4'h5, // Branch and clear bit
        ICE_OP_CARRY    = 4'h6, // Branch on carry
        ICE_OP_TABLE    = 4'h7, // Indirect table jump
        ICE_OP_LOOP     = 4'h8  // Count down loop branch
    } ice_op_t;

    typedef enum logic [1:0] {
        ICE_SRC_ACC      = 2'h0,
        ICE_SRC_BANK     = 2'h1,
        ICE_SRC_DIRECT   = 2'h2,
        ICE_SRC_INDIRECT = 2'h3
    } ice_src_t;

    // ------------------------------------------------------------------
    // Steps, lengths and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  ICE_BYTE_STEP = 8'h01;
    localparam logic [15:0] ICE_PTR_STEP  = 16'h0001;
    localparam logic [15:0] ICE_LEN_SHORT = 16'h0002;
    localparam logic [15:0] ICE_LEN_LONG  = 16'h0003;
    localparam logic [7:0]  ICE_BYTE_RST  = 8'h00;
    localparam logic [15:0] ICE_WORD_RST  = 16'h0000;
    localparam logic [7:0]  ICE_BYTE_ZERO = 8'h00;

endpackage

// *** ice_target.sv ***
// Purpose: Branch target and table jump address arithmetic
// Assumes: pc_base is the address of the instruction's first byte
// Notes:   All sums wrap modulo 65536 by their 16-bit width
`timescale 1ns/1ps
module ice_target (
    ice_addr_if.calc a
);
    logic [15:0] rel_ext;

    // ------------------------------------------------------------------
    // Address arithmetic
    // ------------------------------------------------------------------
    // Advance past the instruction first, then add the displacement
    assign a.fall_target = a.pc_base + (a.long_instr ? ice_pkg::ICE_LEN_LONG
                                       : ice_pkg::ICE_LEN_SHORT);
    // Sign extension keeps backward loops correct
    assign rel_ext = {{8{a.rel[7]}}, a.rel};
    assign a.rel_target = a.fall_target + rel_ext;
    // Unsigned accumulator; the carry out of bit 7 ripples upward
    assign a.table_target = {ice_pkg::ICE_BYTE_ZERO, a.acc} + a.sixteen_bit_data_pointer;
endmodule

// *** incr_and_cond_branch_exec_test.sv ***
// Purpose: Self-checking bench for the increment and branch executor
// Assumes: One request every second cycle, result registered on the same edge that takes it
// Notes:   Expected values are worked out here, never read back from DUT
`timescale 1ns/1ps
module incr_and_cond_branch_exec_test;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic              ref_clk;
    logic              arst_n;
    logic              op_valid;
    ice_pkg::ice_op_t  op;
    ice_pkg::ice_src_t src;
    logic              is_port;
    logic [7:0]        operand_in;
    logic [7:0]        port_latch;
    logic              bit_in;
    logic              bit_is_port;
    logic              bit_latch;
    logic              carry_in;
    logic [7:0]        rel_disp;
    logic [15:0]       pc_in;
    logic [15:0]       sixteen_bit_data_pointer_in;
    logic [7:0]        acc_in;
    logic              done_r;
    logic              byte_we_r;
    ice_pkg::ice_src_t byte_dst_r;
    logic [7:0]        byte_out_r;
    logic              pc_we_r;
    logic [15:0]       pc_out_r;
    logic              sixteen_bit_data_pointer_we_r;
    logic [15:0]       sixteen_bit_data_pointer_out_r;
    logic              bit_clr_r;
    int                error_cnt;
    int                checks;

    ice_exec ice_exec_inst (
        .ref_clk(ref_clk), .arst_n(arst_n), .op_valid(op_valid), .op(op),
        .src(src), .is_port(is_port), .operand_in(operand_in),
        .port_latch(port_latch), .bit_in(bit_in), .bit_is_port(bit_is_port),
        .bit_latch(bit_latch), .carry_in(carry_in), .rel_disp(rel_disp),
        .pc_in(pc_in), .sixteen_bit_data_pointer_in(sixteen_bit_data_pointer_in), .acc_in(acc_in), .done_r(done_r),
        .byte_we_r(byte_we_r), .byte_dst_r(byte_dst_r),
        .byte_out_r(byte_out_r), .pc_we_r(pc_we_r), .pc_out_r(pc_out_r),
        .sixteen_bit_data_pointer_we_r(sixteen_bit_data_pointer_we_r), .sixteen_bit_data_pointer_out_r(sixteen_bit_data_pointer_out_r), .bit_clr_r(bit_clr_r)
    );

    // ------------------------------------------------------------------
    // Clock, comparison and closing
    // ------------------------------------------------------------------
    // Core clock, 20 ns period
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Case equality so an unknown output never passes
    task automatic chk(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Single exit point for both normal end and watchdog
    task automatic test_done;
        if (error_cnt == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Branch target: advanced address plus sign-extended displacement
    function automatic logic [15:0] tgt(input logic [15:0] pc,
                                        input logic [15:0] len,
                                        input logic [7:0] r, input logic tk);
        return pc + len + (tk ? {{8{r[7]}}, r} : 16'h0000);
    endfunction

    // One request, then all strobes and the result of each expected write; we = byte,pc,ptr,clear
    task automatic run(input ice_pkg::ice_op_t o,
                       input ice_pkg::ice_src_t s, input logic [7:0] v,
                       input logic [7:0] lat, input logic [4:0] fl,
                       input logic [7:0] r, input logic [15:0] pc,
                       input logic [15:0] dp, input logic [7:0] a,
                       input logic [3:0] we, input logic [7:0] eb,
                       input logic [15:0] ew);
        @(posedge ref_clk);
        op         <= o;
        src        <= s;
        operand_in <= v;
        port_latch <= lat;
        {is_port, carry_in, bit_is_port, bit_latch, bit_in} <= fl;
        rel_disp   <= r;
        pc_in      <= pc;
        sixteen_bit_data_pointer_in    <= dp;
        acc_in     <= a;
        op_valid   <= 1'b1;
        @(posedge ref_clk);
        op_valid   <= 1'b0;
        #1;
        chk("done_r", {15'h0000, done_r}, 16'h0001);
        chk("strobes", {12'h000, byte_we_r, pc_we_r, sixteen_bit_data_pointer_we_r, bit_clr_r},
            {12'h000, we});
        if (we[3])
            chk("byte_out_r", {8'h00, byte_out_r}, {8'h00, eb});
        if (we[2])
            chk("pc_out_r", pc_out_r, ew);
        if (we[1])
            chk("sixteen_bit_data_pointer_out_r", sixteen_bit_data_pointer_out_r, ew);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Outputs sit at reset values; wait an edge, a time-zero fall may be lost
    task automatic t_reset;
        @(posedge ref_clk);
        #1;
        chk("idle", {11'h000, done_r, byte_we_r, pc_we_r, sixteen_bit_data_pointer_we_r,
                     bit_clr_r}, 16'h0000);
        chk("pc_out_r", pc_out_r, ice_pkg::ICE_WORD_RST);
        chk("sixteen_bit_data_pointer_out_r", sixteen_bit_data_pointer_out_r, ice_pkg::ICE_WORD_RST);
        chk("byte_out_r", {8'h00, byte_out_r}, {8'h00, ice_pkg::ICE_BYTE_RST});
        chk("byte_dst_r", {14'h0000, byte_dst_r}, 16'h0000);
    endtask

    // Wrap of all-ones in every operand form, then port latch source
    task automatic t_inc;
        for (int s = 0; s < 4; s++) begin
            run(ice_pkg::ICE_OP_INC, ice_pkg::ice_src_t'(s), 8'hFF, 8'h00,
                5'h00, 8'h00, 16'h0000, 16'h0000, 8'h00, 4'h8, 8'h00, 16'h0000);
            chk("byte_dst_r", {14'h0000, byte_dst_r}, s[15:0]);
        end
        run(ice_pkg::ICE_OP_INC, ice_pkg::ICE_SRC_DIRECT, 8'h10, 8'h7E,
            5'h10, 8'h00, 16'h0000, 16'h0000, 8'h00, 4'h8, 8'h7F, 16'h0000);
    endtask

    // Low byte carry into high byte, full 16-bit wrap; idle op writes nothing
    task automatic t_ptr;
        run(ice_pkg::ICE_OP_NONE, ice_pkg::ICE_SRC_ACC, 8'h00, 8'h00,
            5'h00, 8'h00, 16'h0000, 16'h12FF, 8'h00, 4'h0, 8'h00, 16'h0000);
        run(ice_pkg::ICE_OP_INC_PTR, ice_pkg::ICE_SRC_ACC, 8'h00, 8'h00,
            5'h00, 8'h00, 16'h0000, 16'h12FF, 8'h00, 4'h2, 8'h00, 16'h1300);
        run(ice_pkg::ICE_OP_INC_PTR, ice_pkg::ICE_SRC_ACC, 8'h00, 8'h00,
            5'h00, 8'h00, 16'h0000, 16'hFFFF, 8'h00, 4'h2, 8'h00, 16'h0000);
    endtask

    // Bit tests; a set latch with a clear pin must not fool the pin tests
    task automatic t_bits;
        run(ice_pkg::ICE_OP_BIT_SET, ice_pkg::ICE_SRC_ACC, 8'h00, 8'h00,
            5'h01, 8'h7F, 16'hFFF0, 16'h0000, 8'h00, 4'h4, 8'h00,
            tgt(16'hFFF0, 16'h0003, 8'h7F, 1'b1));
        run(ice_pkg::ICE_OP_BIT_SET, ice_pkg::ICE_SRC_ACC, 8'h00, 8'h00,
            5'h02, 8'h10, 16'h0100, 16'h0000, 8'h00, 4'h4, 8'h00,
            tgt(16'h0100, 16'h0003, 8'h10, 1'b0));
        run(ice_pkg::ICE_OP_BIT_CLR, ice_pkg::ICE_SRC_ACC, 8'h00, 8'h00,
            5'h02, 8'hF0, 16'h0100, 16'h0000, 8'h00, 4'h4, 8'h00,
            tgt(16'h0100, 16'h0003, 8'hF0, 1'b1));
        run(ice_pkg::ICE_OP_BIT_CLR, ice_pkg::ICE_SRC_ACC, 8'h00, 8'h00,
            5'h01, 8'hF0, 16'h0100, 16'h0000, 8'h00, 4'h4, 8'h00,
            tgt(16'h0100, 16'h0003, 8'hF0, 1'b0));
        run(ice_pkg::ICE_OP_BIT_TAKE, ice_pkg::ICE_SRC_ACC, 8'h00, 8'h00,
            5'h06, 8'h10, 16'h0100, 16'h0000, 8'h00, 4'h5, 8'h00,
            tgt(16'h0100, 16'h0003, 8'h10, 1'b1));
        run(ice_pkg::ICE_OP_BIT_TAKE, ice_pkg::ICE_SRC_ACC, 8'h00, 8'h00,
            5'h00, 8'h10, 16'h0100, 16'h0000, 8'h00, 4'h4, 8'h00,
            tgt(16'h0100, 16'h0003, 8'h10, 1'b0));
    endtask

    // Carry set and clear, negative displacement across address zero
    task automatic t_carry;
        run(ice_pkg::ICE_OP_CARRY, ice_pkg::ICE_SRC_ACC, 8'h00, 8'h00,
            5'h08, 8'hFE, 16'h0100, 16'h0000, 8'h00, 4'h4, 8'h00,
            tgt(16'h0100, 16'h0002, 8'hFE, 1'b1));
        run(ice_pkg::ICE_OP_CARRY, ice_pkg::ICE_SRC_ACC, 8'h00, 8'h00,
            5'h00, 8'hFE, 16'h0100, 16'h0000, 8'h00, 4'h4, 8'h00,
            tgt(16'h0100, 16'h0002, 8'hFE, 1'b0));
        run(ice_pkg::ICE_OP_CARRY, ice_pkg::ICE_SRC_ACC, 8'h00, 8'h00,
            5'h08, 8'h80, 16'h0000, 16'h0000, 8'h00, 4'h4, 8'h00,
            tgt(16'h0000, 16'h0002, 8'h80, 1'b1));
    endtask

    // Unsigned accumulator plus pointer, carry and 16-bit wrap
    task automatic t_table;
        run(ice_pkg::ICE_OP_TABLE, ice_pkg::ICE_SRC_ACC, 8'h00, 8'h00,
            5'h00, 8'h00, 16'h0000, 16'h00FF, 8'hFF, 4'h4, 8'h00, 16'h01FE);
        run(ice_pkg::ICE_OP_TABLE, ice_pkg::ICE_SRC_ACC, 8'h00, 8'h00,
            5'h00, 8'h00, 16'h0000, 16'hFFFF, 8'h02, 4'h4, 8'h00, 16'h0001);
    endtask

    // Loop reaching zero falls through; zero wraps and branches back
    task automatic t_loop;
        run(ice_pkg::ICE_OP_LOOP, ice_pkg::ICE_SRC_BANK, 8'h01, 8'h00,
            5'h00, 8'h20, 16'h0100, 16'h0000, 8'h00, 4'hC, 8'h00,
            tgt(16'h0100, 16'h0002, 8'h20, 1'b0));
        run(ice_pkg::ICE_OP_LOOP, ice_pkg::ICE_SRC_DIRECT, 8'h00, 8'h00,
            5'h00, 8'hFC, 16'h0200, 16'h0000, 8'h00, 4'hC, 8'hFF,
            tgt(16'h0200, 16'h0003, 8'hFC, 1'b1));
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    // Inputs settled at time zero so nothing enters the core unknown
    initial begin
        error_cnt = 0;
        checks = 0;
        arst_n = 1'b0;
        op_valid = 1'b0;
        op = ice_pkg::ICE_OP_NONE;
        src = ice_pkg::ICE_SRC_ACC;
        {is_port, carry_in, bit_is_port, bit_latch, bit_in} = 5'h00;
        {operand_in, port_latch, rel_disp, acc_in} = 32'h00000000;
        {pc_in, sixteen_bit_data_pointer_in} = 32'h00000000;
        t_reset;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_inc;
        t_ptr;
        t_bits;
        t_carry;
        t_table;
        t_loop;
        test_done;
    end

    // About 40 cycles of work; a generous limit catches a hang
    initial begin
        repeat (2000) @(posedge ref_clk);
        error_cnt++;
        test_done;
    end

endmodule
